// ---- hdl/psa_pkg.sv ----
// printer status and accessory i/o: shared constants and carriers
// assumes a 50 MHz core clock and a 32-bit axi4-lite register bus
`default_nettype none
package psa_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int END_PULSE_MS = 20;
  localparam int END_PULSE_CYC = CLK_HZ / 1000 * END_PULSE_MS;
  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam int CTRL_LEGACY = 0;
  localparam int CTRL_PS_EN_SW = 1;
  localparam int CTRL_EP_LO = 2;
  localparam int CTRL_EP_HI = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int IRQ_W = 4;
  localparam int IRQ_ENQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_REPRINT = 2;
  localparam int IRQ_PSTART = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // status byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_OFFLINE = 8'h30;
  localparam logic [7:0] BASE_WAIT = 8'h41;
  localparam logic [7:0] BASE_PRINT = 8'h47;
  localparam logic [7:0] BASE_DISPENSE = 8'h4D;
  localparam logic [7:0] BASE_COMPILE = 8'h53;
  localparam logic [7:0] OFS_RNE = 8'h01;
  localparam logic [7:0] OFS_BNF = 8'h02;
  localparam logic [7:0] OFS_BOTH = 8'h03;
  localparam logic [7:0] OFS_STOP = 8'h04;
  localparam logic [7:0] ERR_HEAD_OPEN = 8'h62;
  localparam logic [7:0] ERR_PAPER_END = 8'h63;
  localparam logic [7:0] ERR_RIBBON_END = 8'h64;
  localparam logic [7:0] ERR_MEDIA = 8'h65;
  localparam logic [7:0] ERR_SENSOR = 8'h66;
  localparam logic [7:0] ERR_HEAD = 8'h67;
  localparam logic [7:0] ERR_CUTTER = 8'h6A;
  localparam logic [7:0] ERR_OTHER = 8'h6B;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam int REC_BYTES = 27;
  localparam logic [4:0] REC_LAST_IDX = 5'h1A;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSA_OP_OFFLINE = 3'h0,
    PSA_OP_WAIT = 3'h1,
    PSA_OP_PRINT = 3'h3,
    PSA_OP_DISPENSE = 3'h2,
    PSA_OP_COMPILE = 3'h6
  } psa_op_e;
  typedef enum logic [1:0] {
    PSA_EP_PULSE_LO = 2'h0,
    PSA_EP_LEVEL_LO = 2'h1,
    PSA_EP_LEVEL_HI = 2'h2,
    PSA_EP_PULSE_HI = 2'h3
  } psa_ep_e;
  typedef enum logic {
    PSA_REC_IDLE = 1'b0,
    PSA_REC_SEND = 1'b1
  } psa_rec_e;
  typedef struct packed {
    logic head_open;
    logic paper_end;
    logic ribbon_end;
    logic media_err;
    logic sensor_err;
    logic head_err;
    logic cutter_err;
    logic other_err;
    logic rx_buf_full;
    logic ribbon_near_end;
    logic buffer_near_full;
    logic print_stopped;
  } psa_cond_s;
  typedef struct packed {
    logic [15:0] job_id;
    logic [47:0] remaining;
    logic [127:0] job_name;
  } psa_job_s;
endpackage
`default_nettype wire

// ---- hdl/psa_status_io.sv ----
// printer status byte encoder, framed status record and accessory pins
// assumes all inputs synchronous to core_clk_in; axi4-lite master
// issues at most one write and one read at a time
`default_nettype none
// Functional notes
// (RULE1) off-line, no error: 0x30..0x33 by ribbon/buffer, 0x34 print stopped
// (RULE2) on-line waiting for data: 0x41..0x44, 0x45 print stopped
// (RULE3) on-line printing: 0x47..0x4A, 0x4B print stopped
// (RULE4) on-line waiting to dispense: 0x4D..0x50, 0x51 print stopped
// (RULE5) compiling: 0x53..0x55; both and print stopped report 0x56
// (RULE6) error: 0x62..0x67, 0x6A cutter, 0x6B other, fixed priority
// (RULE7) legacy mode drops print-stopped codes and compiling both-code
// (RULE8) ribbon-near-end pin high when near end, low once exhausted
// (RULE9) error pin low on any error, including receive buffer full
// (RULE10) reprint input falling edge requests one duplicate of last label
// (RULE11) print-start pulled low prints one label, only with switch off
// (RULE12) end-print output uses one of four waveforms chosen by two bits
// (RULE13) label-out pin low while a label-out error exists
// (RULE14) ribbon-out pin low while ribbon is exhausted
// (RULE15) off-line pin low while off-line
// (RULE16) enquiry answered with framed 27-byte record carrying status byte
// (RULE17) any error code takes precedence over non-error state codes
module psa_status_io #(
  parameter int END_PULSE_CYC = psa_pkg::END_PULSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [psa_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [psa_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire psa_pkg::psa_op_e op_state_in,
  input wire psa_pkg::psa_cond_s cond_in,
  input wire psa_pkg::psa_job_s job_in,
  input wire logic print_cycle_in,
  input wire logic print_done_in,
  input wire logic enq_in,
  output logic [7:0] rec_byte_out,
  output logic rec_valid_out,
  output logic rec_last_out,
  input wire logic rec_ready_in,
  input wire logic reprint_n_in,
  input wire logic print_start_n_in,
  output logic reprint_req_out,
  output logic print_one_out,
  output logic [7:0] status_code_out,
  output logic ribbon_near_end_out,
  output logic error_n_out,
  output logic label_out_n_out,
  output logic ribbon_out_n_out,
  output logic offline_n_out,
  output logic end_print_out,
  output logic irq_out
);
  localparam int CW = $clog2(END_PULSE_CYC + 1);
  localparam int FW = psa_pkg::REC_BYTES * 8;
  localparam logic [CW-1:0] PULSE_LOAD = CW'(END_PULSE_CYC);

  if (END_PULSE_CYC < 1)
  begin : g_bad_pulse
    $error("END_PULSE_CYC must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_sel(
    input logic [psa_pkg::ADDR_W-1:0] a);
    // bit 2 flags a mapped word, low bits its index
    case (a)
      psa_pkg::REG_CTRL: reg_sel = 3'h4;
      psa_pkg::REG_STATUS: reg_sel = 3'h5;
      psa_pkg::REG_IRQ_STAT: reg_sel = 3'h6;
      psa_pkg::REG_IRQ_MASK: reg_sel = 3'h7;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] encode_status(
    input psa_pkg::psa_op_e op, input psa_pkg::psa_cond_s c,
    input logic legacy);
    logic [7:0] base;
    logic [7:0] ofs;
    base = psa_pkg::BASE_OFFLINE;
    ofs = 8'h00;
    unique case (op)
      psa_pkg::PSA_OP_OFFLINE: base = psa_pkg::BASE_OFFLINE; // [RULE1]
      psa_pkg::PSA_OP_WAIT: base = psa_pkg::BASE_WAIT; // [RULE2]
      psa_pkg::PSA_OP_PRINT: base = psa_pkg::BASE_PRINT; // [RULE3]
      psa_pkg::PSA_OP_DISPENSE: base = psa_pkg::BASE_DISPENSE; // [RULE4]
      psa_pkg::PSA_OP_COMPILE: base = psa_pkg::BASE_COMPILE; // [RULE5]
      default: base = psa_pkg::BASE_OFFLINE;
    endcase
    if (c.print_stopped && !legacy)
      ofs = psa_pkg::OFS_STOP; // [RULE7]
    else if (c.ribbon_near_end && c.buffer_near_full)
      ofs = psa_pkg::OFS_BOTH;
    else if (c.buffer_near_full)
      ofs = psa_pkg::OFS_BNF;
    else if (c.ribbon_near_end)
      ofs = psa_pkg::OFS_RNE;
    // compiling folds both codes onto one; legacy keeps buffer code
    if (op == psa_pkg::PSA_OP_COMPILE && ofs > psa_pkg::OFS_BNF)
      ofs = legacy ? psa_pkg::OFS_BNF : psa_pkg::OFS_BOTH; // [RULE5] [RULE7]
    // error group wins over every state code
    if (c.head_open) // [RULE6] [RULE17]
      encode_status = psa_pkg::ERR_HEAD_OPEN;
    else if (c.paper_end) encode_status = psa_pkg::ERR_PAPER_END;
    else if (c.ribbon_end) encode_status = psa_pkg::ERR_RIBBON_END;
    else if (c.media_err) encode_status = psa_pkg::ERR_MEDIA;
    else if (c.sensor_err) encode_status = psa_pkg::ERR_SENSOR;
    else if (c.head_err) encode_status = psa_pkg::ERR_HEAD;
    else if (c.cutter_err) encode_status = psa_pkg::ERR_CUTTER;
    else if (c.other_err) encode_status = psa_pkg::ERR_OTHER;
    else encode_status = base + ofs;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [psa_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [3:0] ctrl_r;
  logic [psa_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
  logic [2:0] wsel;
  logic do_write;
  logic [7:0] status_r;
  logic [5:0] pins;

  assign s_axi_awready_out = !aw_got_r && !bvalid_r;
  assign s_axi_wready_out = !w_got_r && !bvalid_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;
  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign wsel = reg_sel(aw_addr_r);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end
      else if (do_write)
        aw_got_r <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb0_r <= s_axi_wstrb_in[0];
      end
      else if (do_write)
        w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= psa_pkg::RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (do_write)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wsel[2] ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= psa_pkg::RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= psa_pkg::RESP_OKAY;
        unique case (reg_sel(s_axi_araddr_in))
          3'h4: rdata_r <= {28'h000_0000, ctrl_r};
          3'h5: rdata_r <= {18'h0_0000, pins, status_r};
          3'h6: rdata_r <= {28'h000_0000, irq_stat_r};
          3'h7: rdata_r <= {28'h000_0000, irq_mask_r};
          default:
          begin
            rdata_r <= '0;
            rresp_r <= psa_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready_in)
        rvalid_r <= 1'b0;
    end
  end

  // ctrl: legacy protocol, print-start enable switch, end-print type
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_r <= psa_pkg::CTRL_RST;
      irq_mask_r <= '0;
    end
    else if (ce_in && do_write && wstrb0_r)
    begin
      if (wsel == 3'h4)
        ctrl_r <= wdata_r[3:0];
      if (wsel == 3'h7)
        irq_mask_r <= wdata_r[psa_pkg::IRQ_W-1:0];
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_stat_r <= '0;
    else if (ce_in)
    begin
      if (do_write && wstrb0_r && wsel == 3'h6)
        irq_stat_r <= (irq_stat_r & ~wdata_r[psa_pkg::IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_r <= irq_stat_r | irq_ev;
    end
  end
  assign irq_out = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // status byte and accessory pins
  // ----------------------------------------------------------------
  logic legacy, ps_en_sw, err_any, err_r;
  logic reprint_d_r, start_d_r;
  psa_pkg::psa_ep_e ep_type;
  assign legacy = ctrl_r[psa_pkg::CTRL_LEGACY];
  assign ps_en_sw = ctrl_r[psa_pkg::CTRL_PS_EN_SW];
  assign ep_type = psa_pkg::psa_ep_e'(
    {ctrl_r[psa_pkg::CTRL_EP_HI], ctrl_r[psa_pkg::CTRL_EP_LO]});
  assign err_any = cond_in.head_open || cond_in.paper_end ||
    cond_in.ribbon_end || cond_in.media_err || cond_in.sensor_err ||
    cond_in.head_err || cond_in.cutter_err || cond_in.other_err ||
    cond_in.rx_buf_full;
  assign status_code_out = status_r;
  assign pins = {ribbon_near_end_out, error_n_out, label_out_n_out,
    ribbon_out_n_out, offline_n_out, end_print_out};

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_r <= psa_pkg::BASE_OFFLINE;
      ribbon_near_end_out <= 1'b0;
      error_n_out <= 1'b1;
      label_out_n_out <= 1'b1;
      ribbon_out_n_out <= 1'b1;
      offline_n_out <= 1'b0;
      err_r <= 1'b0;
    end
    else if (ce_in)
    begin
      status_r <= encode_status(op_state_in, cond_in, legacy);
      ribbon_near_end_out <= cond_in.ribbon_near_end &&
        !cond_in.ribbon_end; // [RULE8]
      error_n_out <= !err_any; // [RULE9]
      label_out_n_out <= !cond_in.paper_end; // [RULE13]
      ribbon_out_n_out <= !cond_in.ribbon_end; // [RULE14]
      offline_n_out <= op_state_in != psa_pkg::PSA_OP_OFFLINE; // [RULE15]
      err_r <= err_any;
    end
  end

  // accessory inputs idle high; a pull to ground is one request
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reprint_d_r <= 1'b1;
      start_d_r <= 1'b1;
      reprint_req_out <= 1'b0;
      print_one_out <= 1'b0;
    end
    else if (ce_in)
    begin
      reprint_d_r <= reprint_n_in;
      start_d_r <= print_start_n_in;
      reprint_req_out <= reprint_d_r && !reprint_n_in; // [RULE10]
      print_one_out <= start_d_r && !print_start_n_in && !ps_en_sw; // [RULE11]
    end
  end

  // end-print waveform; pulse types time out on the counter
  logic [CW-1:0] ep_cnt_r;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ep_cnt_r <= '0;
      end_print_out <= 1'b1;
    end
    else if (ce_in)
    begin
      if (print_done_in)
        ep_cnt_r <= PULSE_LOAD;
      else if (ep_cnt_r != '0)
        ep_cnt_r <= ep_cnt_r - CW'(1);
      unique case (ep_type) // [RULE12]
        psa_pkg::PSA_EP_PULSE_LO:
          end_print_out <= !(print_done_in || ep_cnt_r > CW'(1));
        psa_pkg::PSA_EP_LEVEL_LO: end_print_out <= !print_cycle_in;
        psa_pkg::PSA_EP_LEVEL_HI: end_print_out <= print_cycle_in;
        psa_pkg::PSA_EP_PULSE_HI:
          end_print_out <= print_done_in || ep_cnt_r > CW'(1);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status record: stx, id(2), status, remaining(6), name(16), etx
  // ----------------------------------------------------------------
  psa_pkg::psa_rec_e rec_st_r;
  logic [FW-1:0] frame_r;
  logic [4:0] rec_idx_r;
  logic rec_start, rec_take;
  assign rec_start = enq_in && rec_st_r == psa_pkg::PSA_REC_IDLE;
  assign rec_take = rec_valid_out && rec_ready_in;
  assign rec_valid_out = rec_st_r == psa_pkg::PSA_REC_SEND;
  assign rec_byte_out = frame_r[FW-1 -: 8];
  assign rec_last_out = rec_valid_out && rec_idx_r == psa_pkg::REC_LAST_IDX;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rec_st_r <= psa_pkg::PSA_REC_IDLE;
      frame_r <= '0;
      rec_idx_r <= '0;
    end
    else if (ce_in)
    begin
      unique case (rec_st_r)
        psa_pkg::PSA_REC_IDLE:
          if (enq_in)
          begin
            rec_st_r <= psa_pkg::PSA_REC_SEND;
            rec_idx_r <= '0;
            frame_r <= {psa_pkg::CH_STX, job_in.job_id, status_r,
              job_in.remaining, job_in.job_name, psa_pkg::CH_ETX}; // [RULE16]
          end
        psa_pkg::PSA_REC_SEND:
          if (rec_take)
          begin
            frame_r <= {frame_r[FW-9:0], 8'h00};
            rec_idx_r <= rec_idx_r + 5'h01;
            if (rec_last_out)
              rec_st_r <= psa_pkg::PSA_REC_IDLE;
          end
      endcase
    end
  end

  assign irq_ev = {print_one_out, reprint_req_out, err_any && !err_r,
    rec_take && rec_last_out};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  sequence s_rec_open;
    rec_start ##1 rec_valid_out && rec_byte_out == psa_pkg::CH_STX;
  endsequence
  sequence s_rec_close;
    rec_take && rec_last_out ##1 !rec_valid_out;
  endsequence

  a_rec_frame_start: assert property (rec_start |-> s_rec_open) // [RULE16]
    else $error("record does not open with stx");
  a_rec_frame_end: assert property (rec_last_out |-> // [RULE16]
    rec_byte_out == psa_pkg::CH_ETX and (rec_ready_in |-> s_rec_close))
    else $error("record does not close with etx");
  a_status_err_first: assert property ((cond_in.head_open || // [RULE17]
    cond_in.other_err) |=> status_code_out >= psa_pkg::ERR_HEAD_OPEN)
    else $error("error code not preferred");
  a_status_legacy_stop: assert property (legacy && // [RULE7]
    cond_in.print_stopped && !err_any && op_state_in == psa_pkg::PSA_OP_WAIT
    |=> status_code_out != psa_pkg::BASE_WAIT + psa_pkg::OFS_STOP)
    else $error("legacy mode reported print stop");
  a_error_pin_low: assert property (err_any |=> !error_n_out) // [RULE9]
    else $error("error pin not low on error");
  a_ribbon_pins: assert property (cond_in.ribbon_end |=> // [RULE14]
    !ribbon_out_n_out && !ribbon_near_end_out)
    else $error("ribbon pins wrong when exhausted");
  a_offline_pin: assert property ($changed(op_state_in) |=> // [RULE15]
    offline_n_out == ($past(op_state_in) != psa_pkg::PSA_OP_OFFLINE) [*2])
    else $error("off-line pin does not follow state");
  a_start_gated: assert property ($fell(print_start_n_in) |=> // [RULE11]
    print_one_out == !$past(ps_en_sw) ##1 !print_one_out)
    else $error("print start not one gated pulse");
  a_reprint_pulse: assert property ($fell(reprint_n_in) |=> // [RULE10]
    reprint_req_out ##1 !reprint_req_out)
    else $error("reprint request not one pulse");
  a_end_pulse_lo: assert property (print_done_in && // [RULE12]
    ep_type == psa_pkg::PSA_EP_PULSE_LO |=> !end_print_out)
    else $error("end-print type one pulse missing");
endmodule
`default_nettype wire

// ---- tb/psa_far_model.sv ----
// far side model: accessory pulling its inputs low, and a record sink
// assumes go pulses from the bench last one cycle
`default_nettype none
module psa_far_model
(
  input wire logic core_clk_in,
  input wire logic reprint_go_in,
  input wire logic start_go_in,
  input wire logic slow_in,
  output logic reprint_n_out,
  output logic print_start_n_out,
  output logic rec_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rp_r = 3'h0;
  logic [2:0] ps_r = 3'h0;
  logic tog_r = 1'h0;
  // three-cycle pull-down so the sampler sees one clean fall
  always_ff @(posedge core_clk_in)
  begin
    rp_r <= {rp_r[1:0], reprint_go_in};
    ps_r <= {ps_r[1:0], start_go_in};
    tog_r <= ~tog_r;
  end
  assign reprint_n_out = ~|rp_r;
  assign print_start_n_out = ~|ps_r;
  // a slow sink takes a byte on alternate cycles only
  assign rec_ready_out = ~slow_in | tog_r;
endmodule
`default_nettype wire

// ---- tb/test_psa_status_io.sv ----
// self-checking bench for the status encoder and accessory pins
// assumes psa_pkg compiled first; end pulse shortened to 8 cycles
`default_nettype none
module test_psa_status_io;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EP = 8;
  logic clk = 1'h0, rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rb, code;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic awr, wr, bv, arr, rv, recv, recl, recr, rpn, psn, rpq, p1;
  logic rne, errn, lon, ron, offn, ep, irq;
  logic [1:0] bresp, rresp, r;
  psa_pkg::psa_op_e op = psa_pkg::PSA_OP_OFFLINE;
  psa_pkg::psa_cond_s cond = '0;
  psa_pkg::psa_job_s job = '0;
  logic pc = 1'h0, pd = 1'h0, enq = 1'h0, rgo = 1'h0, sgo = 1'h0;
  logic slow = 1'h0, ce = 1'h1;
  int fails = 0, num_checks = 0;
  always #10 clk = ~clk;
  psa_status_io #(.END_PULSE_CYC(EP)) dut (.core_clk_in(clk),
    .rst_in(rst), .ce_in(ce), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .op_state_in(op),
    .cond_in(cond), .job_in(job), .print_cycle_in(pc),
    .print_done_in(pd), .enq_in(enq), .rec_byte_out(rb),
    .rec_valid_out(recv), .rec_last_out(recl), .rec_ready_in(recr),
    .reprint_n_in(rpn), .print_start_n_in(psn), .reprint_req_out(rpq),
    .print_one_out(p1), .status_code_out(code),
    .ribbon_near_end_out(rne), .error_n_out(errn),
    .label_out_n_out(lon), .ribbon_out_n_out(ron),
    .offline_n_out(offn), .end_print_out(ep), .irq_out(irq));
  psa_far_model far (.core_clk_in(clk), .reprint_go_in(rgo),
    .start_go_in(sgo), .slow_in(slow), .reprint_n_out(rpn),
    .print_start_n_out(psn), .rec_ready_out(recr));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (aw && awr === 1'h1)
      begin
        aw = 1'h0;
        awv <= 1'h0;
      end
      if (w && wr === 1'h1)
      begin
        w = 1'h0;
        wv <= 1'h0;
      end
    end while (aw || w);
    do @(posedge clk); while (bv !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge clk); while (rv !== 1'h1);
    r = rresp;
    rb = rdata[7:0];
    rready <= 1'h0;
  endtask
  task automatic set_in(input psa_pkg::psa_op_e o, input logic [11:0] c);
    @(posedge clk);
    op <= o;
    cond <= c;
    tick(2);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    chk("offline pin", 0, offn);
    chk("reset code", 8'h30, code);
    axr(psa_pkg::REG_CTRL);
    chk("ctrl reset", 0, rb);
    axw(psa_pkg::REG_CTRL, 32'h0000_000A);
    axr(psa_pkg::REG_CTRL);
    chk("ctrl", 8'h0A, rb);
    axw(8'h10, 32'h0000_0001);
    chk("unmapped write", psa_pkg::RESP_SLVERR, r);
    axr(8'h10);
    chk("unmapped read", psa_pkg::RESP_SLVERR, r);
    axw(psa_pkg::REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_codes;
    psa_pkg::psa_op_e o[5] = '{psa_pkg::PSA_OP_OFFLINE,
      psa_pkg::PSA_OP_WAIT, psa_pkg::PSA_OP_PRINT,
      psa_pkg::PSA_OP_DISPENSE, psa_pkg::PSA_OP_COMPILE};
    logic [11:0] cf[5] = '{12'h000, 12'h004, 12'h002, 12'h006, 12'h001};
    logic [7:0] b[5] = '{8'h30, 8'h41, 8'h47, 8'h4D, 8'h53};
    for (int i = 0; i < 5; i++)
      for (int k = 0; k < 5; k++)
      begin
        set_in(o[i], cf[k]);
        chk("code", b[i] + ((i == 4 && k == 4) ? 3 : k), code);
        chk("offline pin", i != 0, offn);
        chk("near end", k == 1 || k == 3, rne);
      end
    axw(psa_pkg::REG_CTRL, 32'h0000_0001);
    set_in(psa_pkg::PSA_OP_WAIT, 12'h001);
    chk("legacy stop", 8'h41, code);
    set_in(psa_pkg::PSA_OP_COMPILE, 12'h006);
    chk("legacy both", 8'h55, code);
    axw(psa_pkg::REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_errors;
    logic [7:0] e[8] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
                         8'h6A, 8'h6B};
    for (int i = 0; i < 8; i++)
    begin
      set_in(psa_pkg::PSA_OP_PRINT, (12'h800 >> i) | 12'h006);
      chk("error code", e[i], code);
      chk("error pin", 0, errn);
      chk("label out", i != 1, lon);
      chk("ribbon out", i != 2, ron);
      chk("near end", i != 2, rne);
    end
    set_in(psa_pkg::PSA_OP_PRINT, 12'h008);
    chk("buffer full pin", 0, errn);
    set_in(psa_pkg::PSA_OP_WAIT, 12'h000);
    chk("error pin idle", 1, errn);
  endtask
  task automatic go(input logic s, output int n);
    @(posedge clk);
    if (s)
      sgo <= 1'h1;
    else
      rgo <= 1'h1;
    @(posedge clk);
    sgo <= 1'h0;
    rgo <= 1'h0;
    n = 0;
    repeat (10)
    begin
      tick(1);
      n += s ? p1 : rpq;
    end
  endtask
  task automatic t_access;
    int n;
    axw(psa_pkg::REG_IRQ_STAT, 32'h0000_000F);
    axw(psa_pkg::REG_IRQ_MASK, 32'h0000_0000);
    go(1'h0, n);
    chk("reprint pulses", 1, n);
    go(1'h1, n);
    chk("start pulses", 1, n);
    axw(psa_pkg::REG_CTRL, 32'h0000_0002);
    go(1'h1, n);
    chk("start disabled", 0, n);
    chk("irq masked", 0, irq);
    axw(psa_pkg::REG_IRQ_MASK, 32'h0000_0004);
    tick(1);
    chk("irq raised", 1, irq);
    axr(psa_pkg::REG_IRQ_STAT);
    chk("irq status", 8'h0C, rb);
    axw(psa_pkg::REG_IRQ_STAT, 32'h0000_0004);
    tick(1);
    chk("irq cleared", 0, irq);
    ce <= 1'h0;
    go(1'h0, n);
    ce <= 1'h1;
    chk("frozen", 0, n);
    axw(psa_pkg::REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_record;
    logic [7:0] q[$];
    job <= {16'h1234, 48'h0000_0000_0005, 128'h4142};
    slow <= 1'h1;
    set_in(psa_pkg::PSA_OP_WAIT, 12'h004);
    enq <= 1'h1;
    @(posedge clk);
    enq <= 1'h0;
    repeat (100)
    begin
      @(posedge clk);
      if (recv === 1'h1 && recr === 1'h1)
      begin
        q.push_back(rb);
        if (recl === 1'h1)
          break;
      end
    end
    chk("record length", 27, q.size());
    chk("start byte", 8'h02, q[0]);
    chk("id high", 8'h12, q[1]);
    chk("status byte", 8'h42, q[3]);
    chk("end byte", 8'h03, q[26]);
    slow <= 1'h0;
  endtask
  task automatic t_endprint;
    logic idle;
    int n;
    for (int t = 0; t < 4; t++)
    begin
      axw(psa_pkg::REG_CTRL, t << 2);
      tick(2);
      idle = ep;
      chk("end idle", t < 2, idle);
      @(posedge clk);
      pc <= (t == 1 || t == 2);
      pd <= (t == 0 || t == 3);
      @(posedge clk);
      pd <= 1'h0;
      n = 0;
      repeat (20)
      begin
        #1;
        n += (ep !== idle);
        @(posedge clk);
      end
      pc <= 1'h0;
      chk("end active", (t == 0 || t == 3) ? EP : 20, n);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    tick(1);
    t_regs();
    t_codes();
    t_errors();
    t_access();
    t_record();
    t_endprint();
    end_of_test();
  end
  initial
  begin
    #200_000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
